// >>> dv/tmr_counter16_props.sv
/* assertions on the timer/counter top ports.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module tmr_counter16_props
    import tmr_count_pkg::*;
(
    input wire logic clk_sys_in, // clock
    input wire logic rst_in, // reset
    input wire logic [7:0] addr_in, // address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [7:0] rdata_out, // read data
    input wire logic ext_count_in, // count pin
    input wire logic crystal_in_pin_in, // crystal in
    input wire logic crystal_out_pin_out, // crystal out
    input wire logic crystal_out_pin_oe_out, // crystal oe
    input wire logic sleep_in, // sleep
    input wire logic [3:0] compare_unit_mode_in, // compare mode
    input wire logic compare_match_in, // match pulse
    input wire logic irq_out, // interrupt
    input wire logic osc_running_out // oscillator on
);
    // ************************************************************
    // shadow of the overflow enable, so irq can be tied to its cause
    // ************************************************************
    logic ien_ff;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ien_ff <= 1'b0;
        end else if (wr_in && addr_in == ADDR_IRQ_ENABLES) begin
            ien_ff <= wdata_in[BIT_OVF];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == BYTE_ZERO)
        else $error("read data outside its slot");
    a_control_top_zero: assert property (rd_in && addr_in == ADDR_CONTROL |=> rdata_out[7:6] == 2'h0)
        else $error("control top bits not zero");
    a_flag_top_zero: assert property (rd_in && addr_in == ADDR_IRQ_FLAGS |=> rdata_out[7:1] == 7'h00)
        else $error("flag register top bits not zero");
    a_enable_readback: assert property (rd_in && addr_in == ADDR_IRQ_ENABLES |=> rdata_out == {7'h00, ien_ff})
        else $error("enable read back wrong");
    a_irq_masked_low: assert property (!ien_ff && !$past(ien_ff) |-> !irq_out)
        else $error("irq while masked");
    a_osc_pair_equal: assert property (osc_running_out == crystal_out_pin_oe_out)
        else $error("oscillator flags disagree");
    a_crystal_inverts: assert property ($past(crystal_out_pin_oe_out) && crystal_out_pin_oe_out
        |-> crystal_out_pin_out == !$past(crystal_in_pin_in))
        else $error("crystal output not inverted input");
    a_osc_start_bound: assert property (wr_in && addr_in == ADDR_CONTROL && wdata_in[BIT_OSC_EN]
        |-> ##[1:2] crystal_out_pin_oe_out)
        else $error("oscillator did not start");
endmodule : tmr_counter16_props
bind tmr_counter16 tmr_counter16_props u_props (.*);

// >>> dv/tmr_counter16_tb.sv
/* self-checking bench of the timer/counter.
   assumes the checker binds itself to the design. */
`timescale 1ns/1ps
module tmr_counter16_tb;
    import tmr_count_pkg::*;
    logic clk_sys_in, rst_in, wr_in, rd_in, sleep_in, compare_match_in, ext_count_in, crystal_in_pin_in;
    logic crystal_out_pin_out, crystal_out_pin_oe_out, irq_out, osc_running_out;
    logic [7:0] addr_in, wdata_in, rdata_out, v;
    logic [3:0] compare_unit_mode_in;
    int miscompares = 0;
    int checks_done = 0;
    tmr_counter16 DUT (.*);
    tmr_pulse_source src (.clk_sys_in(clk_sys_in), .pin_out(ext_count_in), .xtal_out(crystal_in_pin_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        // one idle edge, so a following write never re-raises the strobe in this step
        @(posedge clk_sys_in);
    endtask : wr
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
        @(posedge clk_sys_in);
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(v, exp);
    endtask : rdchk
    task automatic zero();
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
    endtask : zero
    task automatic test_reset();
        rdchk(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_IRQ_ENABLES, 8'h00);
        rdchk(8'h55, 8'h00);
        wr(ADDR_CONTROL, 8'hFE);
        rdchk(ADDR_CONTROL, 8'h3E);
        chk({7'h00, osc_running_out}, 8'h01);
        wr(ADDR_COUNT_LOW, 8'h5A);
        rst_in <= 1'b1;
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        rdchk(ADDR_COUNT_LOW, 8'h5A);
        rdchk(ADDR_CONTROL, 8'h00);
        $display("test reset done");
    endtask : test_reset
    task automatic test_timer();
        logic [7:0] h;
        zero();
        wr(ADDR_CONTROL, 8'h05);
        repeat (40) @(posedge clk_sys_in);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_LOW);
        chk((v > 8'h08 && v < 8'h0C) ? 8'h01 : v, 8'h01);
        repeat (20) @(posedge clk_sys_in);
        rdchk(ADDR_COUNT_LOW, v);
        wr(ADDR_COUNT_HIGH, 8'hFF);
        wr(ADDR_COUNT_LOW, 8'hFE);
        wr(ADDR_CONTROL, 8'h01);
        repeat (16) @(posedge clk_sys_in);
        wr(ADDR_CONTROL, 8'h00);
        rdchk(ADDR_IRQ_FLAGS, 8'h01);
        rdchk(ADDR_COUNT_HIGH, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        wr(ADDR_IRQ_ENABLES, 8'h01);
        repeat (2) @(posedge clk_sys_in);
        chk({7'h00, irq_out}, 8'h01);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        repeat (2) @(posedge clk_sys_in);
        chk({7'h00, irq_out}, 8'h00);
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_COUNT_HIGH);
        h = v;
        rd(ADDR_COUNT_LOW);
        rd(ADDR_COUNT_HIGH);
        if (v != h) begin
            rd(ADDR_COUNT_HIGH);
            h = v;
            rd(ADDR_COUNT_LOW);
        end
        wr(ADDR_CONTROL, 8'h00);
        chk(h, 8'h00);
        $display("test timer done");
    endtask : test_timer
    task automatic test_trigger();
        wr(ADDR_COUNT_HIGH, 8'h12);
        wr(ADDR_COUNT_LOW, 8'h34);
        for (int m = 10; m < 12; m++) begin
            compare_unit_mode_in <= 4'(m);
            compare_match_in <= 1'b1;
            @(posedge clk_sys_in);
            compare_match_in <= 1'b0;
            rdchk(ADDR_COUNT_LOW, (m == 11) ? 8'h00 : 8'h34);
        end
        rdchk(ADDR_COUNT_HIGH, 8'h00);
        rdchk(ADDR_IRQ_FLAGS, 8'h00);
        addr_in <= ADDR_COUNT_LOW;
        wdata_in <= 8'h77;
        wr_in <= 1'b1;
        compare_match_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        compare_match_in <= 1'b0;
        @(posedge clk_sys_in);
        rdchk(ADDR_COUNT_LOW, 8'h77);
        $display("test trigger done");
    endtask : test_trigger
    task automatic test_external();
        for (int ps = 0; ps < 4; ps++) begin
            // leave the prescaler part-way, so only the clear on write gives exact counts
            src.burst(3);
            zero();
            wr(ADDR_CONTROL, {2'h0, 2'(ps), 4'h3});
            src.burst(16);
            repeat (12) @(posedge clk_sys_in);
            wr(ADDR_CONTROL, 8'h00);
            rdchk(ADDR_COUNT_LOW, 8'(16 >> ps));
        end
        for (int b = 0; b < 2; b++) begin
            zero();
            sleep_in <= 1'b1;
            wr(ADDR_CONTROL, (b == 1) ? 8'h07 : 8'h03);
            src.burst(8);
            repeat (12) @(posedge clk_sys_in);
            wr(ADDR_CONTROL, 8'h00);
            sleep_in <= 1'b0;
            rdchk(ADDR_COUNT_LOW, (b == 1) ? 8'h08 : 8'h00);
        end
        wr(ADDR_CONTROL, 8'h08);
        repeat (20) @(posedge clk_sys_in);
        zero();
        wr(ADDR_CONTROL, 8'h0B);
        repeat (100) @(posedge clk_sys_in);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT_LOW);
        chk((v > 8'h08 && v < 8'h0C) ? 8'h01 : v, 8'h01);
        $display("test external done");
    endtask : test_external
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        {rst_in, wr_in, rd_in, sleep_in, compare_match_in} = 5'h10;
        {addr_in, wdata_in, compare_unit_mode_in} = 20'h00000;
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        test_reset();
        test_timer();
        test_trigger();
        test_external();
        results();
    end
endmodule : tmr_counter16_tb

// >>> dv/tmr_pulse_source.sv
/* external clock source and free-running watch crystal.
   assumes it is clocked by the system clock of the bench. */
`timescale 1ns/1ps
module tmr_pulse_source (
    input wire logic clk_sys_in, // clock
    output logic pin_out, // external count pin
    output logic xtal_out // crystal input pin
);
    initial begin
        pin_out = 1'b0;
        xtal_out = 1'b0;
    end
    always begin
        repeat (5) @(posedge clk_sys_in);
        xtal_out <= ~xtal_out;
    end
    // pin rests low between bursts; high and low phases well above two cycles
    task automatic burst(input int n);
        repeat (n) begin
            pin_out <= 1'b1;
            repeat (8) @(posedge clk_sys_in);
            pin_out <= 1'b0;
            repeat (8) @(posedge clk_sys_in);
        end
    endtask : burst
endmodule : tmr_pulse_source

// >>> rtl/tmr_count_pkg.sv
/*
 * constants, register map and field layout of the 16-bit timer/counter.
 * assumes a single 250 MHz system clock; all pins sampled synchronously.
 */
// Functional notes
// - 1:1 sync samples input on Q2/Q4 phases
// - other prescales ripple-divide before synchroniser
// - synced count lags edge by sync latency
// - bypass bit counts unsynced, runs in sleep
// - async mode not a capture/compare base
// - byte reads always stable and valid
// - oscillator enable starts crystal, runs in sleep
// - special event trigger resets counter pair
// - trigger reset never sets overflow flag
// - trigger reset only assured in sync modes
// - software write beats simultaneous trigger reset
// - device resets never clear count bytes
// - control clears on power-on/brown-out only
// - count byte write clears prescaler
// - count up, wrap sets overflow flag
// - prescale field bits 5:4 divide 1/2/4/8; code divides the external source only, internal mode counts every 4th clock
// - bit 1 selects external pin or internal
// - synced mode in sleep: prescaler only
package tmr_count_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h0E;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0F;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8C;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int BIT_ENABLE = 0;
    localparam int BIT_SRC_SEL = 1;
    localparam int BIT_SYNC_BYPASS = 2;
    localparam int BIT_OSC_EN = 3;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_OVF = 0;
    localparam logic [7:0] CONTROL_MASK = 8'h3F;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;

    // ************************************************************
    // prescaler and phase clock
    // ************************************************************
    localparam int PS_BITS = 3;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;

    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b00,
        SYNC_HIGH = 2'b01
    } sync_state_type;

endpackage : tmr_count_pkg

// >>> rtl/tmr_counter16.sv
/*
 * 16-bit timer/counter: registers, count pair, overflow flag, trigger reset.
 * assumes a phase-clock model where internal mode counts every 4th clock.
 */
`timescale 1ns/1ps
module tmr_counter16
    import tmr_count_pkg::*;
(
    input wire logic clk_sys_in, // system clock
    input wire logic rst_in, // async reset, power-on/brown-out
    input wire logic [7:0] addr_in, // register address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [7:0] rdata_out, // read data, cycle after rd_in
    input wire logic ext_count_in, // external count pin
    input wire logic crystal_in_pin_in, // crystal input pin
    output logic crystal_out_pin_out, // crystal amplifier output
    output logic crystal_out_pin_oe_out, // crystal output enable
    input wire logic sleep_in, // processor sleeping
    input wire logic [3:0] compare_unit_mode_in, // compare unit mode field
    input wire logic compare_match_in, // compare unit match pulse
    output logic irq_out, // overflow interrupt / wake request
    output logic osc_running_out // crystal oscillator on
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] control_ff;
    logic [7:0] low_ff;
    logic [7:0] high_ff;
    logic ovf_flag_ff;
    logic ovf_en_ff;
    logic [7:0] rdata_ff;
    logic irq_ff;
    logic osc_out_ff;
    logic osc_oe_ff;
    logic [1:0] cyc_ff;

    tmr_edge_if edge_bus ();

    // ************************************************************
    // decode
    // ************************************************************
    wire wr_ctrl = wr_in & (addr_in == ADDR_CONTROL);
    wire wr_low = wr_in & (addr_in == ADDR_COUNT_LOW);
    wire wr_high = wr_in & (addr_in == ADDR_COUNT_HIGH);
    wire wr_flags = wr_in & (addr_in == ADDR_IRQ_FLAGS);
    wire wr_enables = wr_in & (addr_in == ADDR_IRQ_ENABLES);
    wire ctl_enable = control_ff[BIT_ENABLE];
    wire ctl_ext = control_ff[BIT_SRC_SEL];
    wire ctl_bypass = control_ff[BIT_SYNC_BYPASS];
    wire ctl_osc = control_ff[BIT_OSC_EN];
    // unsynced counting is no time base for compare: its triggers are dropped
    wire async_mode = ctl_ext & ctl_bypass;
    // with the crystal on, the external count source is the oscillator input pin
    wire src_level = ctl_osc ? crystal_in_pin_in : ext_count_in;
    wire int_tick = (cyc_ff == PHASE_Q4);
    wire step = ctl_enable & (ctl_ext ? edge_bus.tick : (int_tick & ~sleep_in));
    wire [15:0] count_now = {high_ff, low_ff};
    wire [15:0] count_inc = count_now + 16'h0001;
    wire wrap = step & (count_now == 16'hFFFF);
    // trigger reset is not guaranteed in async mode; it is simply not applied there
    wire sev = compare_match_in & (compare_unit_mode_in == MODE_SPECIAL_EVENT) & ~async_mode;
    wire [7:0] rd_mux = (addr_in == ADDR_COUNT_LOW) ? low_ff :
                        (addr_in == ADDR_COUNT_HIGH) ? high_ff :
                        (addr_in == ADDR_CONTROL) ? (control_ff & CONTROL_MASK) :
                        (addr_in == ADDR_IRQ_FLAGS) ? {7'h00, ovf_flag_ff} :
                        (addr_in == ADDR_IRQ_ENABLES) ? {7'h00, ovf_en_ff} : BYTE_ZERO;

    assign edge_bus.ps_clear = wr_low | wr_high;
    assign edge_bus.ps_sel = control_ff[BIT_PS_HI:BIT_PS_LO];
    assign edge_bus.ext_sel = ctl_ext;
    assign edge_bus.bypass = ctl_bypass;
    assign edge_bus.run_sync = ~sleep_in;

    tmr_input_stage u_stage (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .src_in(src_level),
        .edge_port(edge_bus)
    );

    // ************************************************************
    // control and interrupt registers
    // ************************************************************
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            control_ff <= CONTROL_RESET;
            ovf_flag_ff <= 1'b0;
            ovf_en_ff <= 1'b0;
            rdata_ff <= BYTE_ZERO;
            irq_ff <= 1'b0;
            cyc_ff <= 2'h0;
            osc_out_ff <= 1'b0;
            osc_oe_ff <= 1'b0;
        end else begin
            cyc_ff <= cyc_ff + 2'h1;
            if (wr_ctrl) begin
                control_ff <= wdata_in & CONTROL_MASK;
            end
            if (wr_enables) begin
                ovf_en_ff <= wdata_in[BIT_OVF];
            end
            // set wins over a simultaneous software clear; trigger never sets it
            if (wrap) begin
                ovf_flag_ff <= 1'b1;
            end else if (wr_flags) begin
                ovf_flag_ff <= wdata_in[BIT_OVF];
            end
            irq_ff <= ovf_flag_ff & ovf_en_ff;
            rdata_ff <= rd_in ? rd_mux : BYTE_ZERO;
            osc_oe_ff <= ctl_osc;
            osc_out_ff <= ctl_osc & ~crystal_in_pin_in;
        end
    end

    // ************************************************************
    // count pair: no reset term, only software, trigger or a count step loads it
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (wr_low | wr_high) begin
            if (wr_low) begin
                low_ff <= wdata_in;
            end
            if (wr_high) begin
                high_ff <= wdata_in;
            end
        end else if (sev) begin
            low_ff <= BYTE_ZERO;
            high_ff <= BYTE_ZERO;
        end else if (step) begin
            low_ff <= count_inc[7:0];
            high_ff <= count_inc[15:8];
        end
    end

    assign rdata_out = rdata_ff;
    assign irq_out = irq_ff;
    assign osc_running_out = osc_oe_ff;
    assign crystal_out_pin_out = osc_out_ff;
    assign crystal_out_pin_oe_out = osc_oe_ff;
endmodule : tmr_counter16

// >>> rtl/tmr_edge_if.sv
/*
 * interface carrying the qualified count tick from the input stage.
 * assumes both ends share clk_sys_in.
 */
`timescale 1ns/1ps
interface tmr_edge_if;
    logic tick;
    logic ps_clear;
    logic [1:0] ps_sel;
    logic ext_sel;
    logic bypass;
    logic run_sync;
    modport stage (output tick, input ps_clear, ps_sel, ext_sel, bypass, run_sync);
    modport core (input tick, output ps_clear, ps_sel, ext_sel, bypass, run_sync);
endinterface : tmr_edge_if

// >>> rtl/tmr_input_stage.sv
/*
 * input stage: ripple-style prescaler, phase sampling, rising-edge tick.
 * assumes ext input already synchronous to clk_sys_in.
 */
`timescale 1ns/1ps
module tmr_input_stage
    import tmr_count_pkg::*;
(
    input wire logic clk_sys_in, // system clock
    input wire logic rst_in, // async reset
    input wire logic src_in, // selected count source level
    tmr_edge_if.stage edge_port // tick to the core
);
    logic [PS_BITS-1:0] div_ff;
    logic src_d_ff;
    logic [1:0] phase_ff;
    logic samp_ff;
    logic samp_d_ff;
    logic tick_ff;
    wire src_rise = src_in & ~src_d_ff;
    wire ps_out = (edge_port.ps_sel == 2'h0) ? src_in : div_ff[edge_port.ps_sel - 2'h1];
    wire ps_prev = (edge_port.ps_sel == 2'h0) ? src_d_ff : 1'b0;
    wire phase_hit = (phase_ff == PHASE_Q2) | (phase_ff == PHASE_Q4);
    // bypass takes edges directly, sync path waits for a phase sample
    wire async_rise = (edge_port.ps_sel == 2'h0) ? src_rise : (ps_out & ~samp_d_ff);
    wire use_bypass = edge_port.ext_sel & edge_port.bypass;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            div_ff <= '0;
            src_d_ff <= 1'b0;
            phase_ff <= 2'h0;
            samp_ff <= 1'b0;
            samp_d_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            src_d_ff <= src_in;
            phase_ff <= phase_ff + 2'h1;
            // symmetric divider keeps counting even when the sync path is idle
            if (edge_port.ps_clear) begin
                div_ff <= '0;
            end else if (src_rise) begin
                div_ff <= div_ff + 3'h1;
            end
            if (phase_hit) begin
                samp_ff <= ps_out;
            end
            samp_d_ff <= use_bypass ? ps_out : samp_ff;
            if (use_bypass) begin
                tick_ff <= async_rise & ~ps_prev;
            end else begin
                tick_ff <= edge_port.run_sync & samp_ff & ~samp_d_ff;
            end
        end
    end
    assign edge_port.tick = tick_ff;
endmodule : tmr_input_stage
